// ==== logic/ctsm_pkg.sv ====
/*
  Constants and types of the tag state machine.
  Assumes a 10 MHz system clock.
*/
`default_nettype none

package ctsm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes

  localparam logic [7:0] OP_REQA      = 8'h26;
  localparam logic [7:0] OP_WUPA      = 8'h52;
  localparam logic [7:0] OP_HLTA      = 8'h50;
  localparam logic [7:0] OP_SEL_CL1   = 8'h93;
  localparam logic [7:0] OP_SEL_CL2   = 8'h95;
  localparam logic [7:0] NVB_SELECT   = 8'h70;
  localparam logic [7:0] OP_READ_FOUR = 8'h30;
  localparam logic [7:0] OP_READ_TWO  = 8'h31;
  localparam logic [7:0] OP_WRITE_ONE = 8'hA2;
  localparam logic [7:0] OP_WRITE_TWO = 8'hA1;
  localparam logic [7:0] OP_COMPAT_WR = 8'hA0;
  localparam logic [7:0] OP_SET_PWD   = 8'hB1;
  localparam logic [7:0] OP_ACCESS    = 8'hB2;
  localparam logic [7:0] OP_DECREMENT = 8'hD0;

  ////////////////////////////////////////////////////////////////////////////
  // frame lengths in bytes, crc included

  localparam logic [4:0] READ_LEN   = 5'h04;
  localparam logic [4:0] HLTA_LEN   = 5'h04;
  localparam logic [4:0] SEL_LEN    = 5'h09;
  localparam logic [4:0] AC_MIN_LEN = 5'h02;
  localparam logic [4:0] AC_MAX_LEN = 5'h07;

  // block counts returned by the two reads
  localparam logic [2:0] BLOCKS_FOUR = 3'h4;
  localparam logic [2:0] BLOCKS_TWO  = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // address limits

  localparam logic [7:0] ADDR_LAST      = 8'h25;
  localparam logic [7:0] ADDR_OPEN_LAST = 8'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // configuration byte fields and reset value

  localparam int         CFG_PWD_EN_BIT = 0;
  localparam int         CFG_RD_PROT_BIT = 1;
  localparam logic [7:0] CFG_RESET       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing

  localparam int CLK_PERIOD_NS = 100;
  localparam int STARTUP_US    = 120;
  // least time: round up
  localparam int STARTUP_CYCLES = (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FDT_NS         = 86400;
  localparam int FDT_CYCLES     = (FDT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 11;

  ////////////////////////////////////////////////////////////////////////////
  // types

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READY1,
    ST_READY2,
    ST_ACTIVE,
    ST_HALT
  } ctsm_state_t;

  typedef enum logic [2:0] {
    REPLY_ATQA,
    REPLY_UID_CL1,
    REPLY_UID_CL2,
    REPLY_SAK_PART,
    REPLY_SAK_DONE,
    REPLY_READ,
    REPLY_NACK_ZERO,
    REPLY_NACK_ONE
  } ctsm_reply_t;

endpackage : ctsm_pkg

`default_nettype wire

// ==== logic/ctsm_reply_if.sv ====
/*
  Reply request from decoder to frame delay timer, and its timed start.
  Assumes one clock at both ends.
*/
`timescale 1ns/10ps
`default_nettype none

interface ctsm_reply_if;

  logic                 req;
  ctsm_pkg::ctsm_reply_t kind;
  logic                 start;
  ctsm_pkg::ctsm_reply_t start_kind;

  modport ctrl  (output req, kind, input start, start_kind);
  modport timer (input req, kind, output start, start_kind);

endinterface : ctsm_reply_if

`default_nettype wire

// ==== logic/ctsm_fdt_timer.sv ====
/*
  Frame delay timer: starts a requested reply a fixed delay later.
  Assumes the request comes with the frame end strobe.
*/
`timescale 1ns/10ps
`default_nettype none

module ctsm_fdt_timer (
  // clock and synchronised reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // reply request and timed start
  ctsm_reply_if.timer     rep
);

  logic [ctsm_pkg::CNT_W-1:0] count;
  logic                       pending;

  ////////////////////////////////////////////////////////////////////////////
  // delay count; a newer request restarts it, an older reply is dropped
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count   <= '0;
      pending <= 1'b0;
    end
    else if (rep.req)
    begin
      count   <= ctsm_pkg::CNT_W'(ctsm_pkg::FDT_CYCLES - 1);
      pending <= 1'b1;
    end
    else if (pending && count == '0)
    begin
      pending <= 1'b0;
    end
    else if (pending)
    begin
      count <= count - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // kind captured with the request, start strobe at the end of the delay
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rep.start_kind <= ctsm_pkg::REPLY_ATQA;
    end
    else if (rep.req)
    begin
      rep.start_kind <= rep.kind;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rep.start <= 1'b0;
    end
    else
    begin
      rep.start <= pending && !rep.req && count == '0;
    end
  end

endmodule : ctsm_fdt_timer

`default_nettype wire

// ==== logic/ctsm_tag.sv ====
/*
  Protocol state machine of a contactless memory tag.
  Assumes a front end giving one decoded frame per frame_valid_i pulse
  and a memory unit that runs the memory commands handed to it.
*/
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - power-up enters idle.
// - idle: REQA or WUPA to ready1; else silent, stay.
// - proper HLTA in active: halt, no reply.
// - halt: only WUPA wakes to ready1; else silent, stay.
// - ready1 runs level 1; select to ready2, SAK incomplete.
// - ready2 runs level 2; select to active, SAK complete.
// - valid-address read in ready1/ready2 not denied by config goes straight to active.
// - reads in ready states behave, errors too, as in active.
// - other frames in ready states return silently.
// - error return to halt if woken from halt, else idle.
// - memory commands only in active.
// - verified password opens all; else blocks above 0F follow config.
// - config latched on each wake by REQA or WUPA, held until next.
// - replies start one frame delay after the last pause.
// - only valid frames are answered.
// - idle/halt errors silent, stay; ready errors silent, return, except reads, which nack as in active.
// - active bad opcode or length: no reply, return.
// - active parity, coding, crc error: nack_code_one, return.
// - active bad address or other error: nack_code_zero, return.
// - REQA 26h, WUPA 52h, HLTA 50h, select 93h/95h with 70h.
// - read_four_blocks 30h gives 16 bytes, read_two_blocks 31h 8.
// - block addresses 00h to 25h only.

module ctsm_tag (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // received frame from the front end
  input  wire logic       frame_valid_i,
  input  wire logic       frame_short_i,
  input  wire logic [4:0] frame_len_i,
  input  wire logic [7:0] frame_op_i,
  input  wire logic [7:0] frame_arg_i,
  input  wire logic       err_parity_i,
  input  wire logic       err_miller_i,
  input  wire logic       err_crc_i,
  input  wire logic       uid_match_i,
  // nonvolatile configuration byte
  input  wire logic [7:0] cfg_nv_i,
  // memory command unit
  input  wire logic       acs_pass_i,
  input  wire logic       acs_fail_i,
  input  wire logic       mem_err_i,
  output logic            mem_cmd_o,
  output logic [7:0]      mem_op_o,
  output logic [7:0]      mem_arg_o,
  output logic            rd_start_o,
  output logic [7:0]      rd_addr_o,
  output logic [2:0]      rd_blocks_o,
  output logic            access_full_o,
  output logic [7:0]      cfg_latched_o,
  // reply to the transmitter
  output logic            reply_start_o,
  output logic [2:0]      reply_kind_o,
  // status
  output logic [2:0]      state_o,
  output logic            from_halt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic addr_ok(input logic [7:0] addr);
    addr_ok = addr <= ctsm_pkg::ADDR_LAST;
  endfunction : addr_ok

  function automatic logic is_read(input logic [7:0] op);
    is_read = op == ctsm_pkg::OP_READ_FOUR || op == ctsm_pkg::OP_READ_TWO;
  endfunction : is_read

  function automatic logic is_mem_op(input logic [7:0] op);
    is_mem_op = op == ctsm_pkg::OP_WRITE_ONE || op == ctsm_pkg::OP_WRITE_TWO ||
                op == ctsm_pkg::OP_COMPAT_WR || op == ctsm_pkg::OP_SET_PWD ||
                op == ctsm_pkg::OP_ACCESS || op == ctsm_pkg::OP_DECREMENT;
  endfunction : is_mem_op

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                  rst_q1;
  logic                  rst_q2;
  logic                  rstn;
  ctsm_pkg::ctsm_state_t state;
  ctsm_pkg::ctsm_state_t next_state;
  logic                  from_halt;
  logic                  verified;
  logic [7:0]            cfg;
  logic [ctsm_pkg::CNT_W-1:0] startup_cnt;
  logic                  started;
  logic                  frame_err;
  logic                  read_denied;
  logic                  ret_req;
  logic                  wake;
  logic                  rep_req;
  ctsm_pkg::ctsm_reply_t rep_kind;
  logic                  rd_go;
  logic                  mem_go;
  ctsm_pkg::ctsm_state_t ret_state;
  logic                  sel_hdr;

  ctsm_reply_if rep ();

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  assign rstn = rst_q2;

  ////////////////////////////////////////////////////////////////////////////
  // start-up guard: frames before it elapses are simply dropped, which is
  // one legal outcome of the reader breaking its wait
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      startup_cnt <= '0;
    end
    else if (!started)
    begin
      startup_cnt <= startup_cnt + 1'b1;
    end
  end

  assign started = startup_cnt == ctsm_pkg::CNT_W'(ctsm_pkg::STARTUP_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // frame qualification
  assign frame_err   = err_parity_i || err_miller_i || err_crc_i;
  assign ret_state   = from_halt ? ctsm_pkg::ST_HALT : ctsm_pkg::ST_IDLE;
  // only blocks above the open area are gated by the latched rights
  assign read_denied = frame_arg_i > ctsm_pkg::ADDR_OPEN_LAST &&
                       cfg[ctsm_pkg::CFG_PWD_EN_BIT] &&
                       cfg[ctsm_pkg::CFG_RD_PROT_BIT] && !verified;
  // clean select or anticollision header of this cascade level
  assign sel_hdr     = !frame_err && !frame_short_i && uid_match_i &&
                       frame_op_i == (state == ctsm_pkg::ST_READY1 ?
                                      ctsm_pkg::OP_SEL_CL1 : ctsm_pkg::OP_SEL_CL2);

  ////////////////////////////////////////////////////////////////////////////
  // command decoder, one frame per pulse
  always_comb
  begin
    next_state = state;
    ret_req    = 1'b0;
    wake       = 1'b0;
    rep_req    = 1'b0;
    rep_kind   = ctsm_pkg::REPLY_ATQA;
    rd_go      = 1'b0;
    mem_go     = 1'b0;
    if (frame_valid_i && started)
    begin
      if (state != ctsm_pkg::ST_IDLE && state != ctsm_pkg::ST_HALT &&
          !frame_short_i && is_read(frame_op_i))
      begin
        // reads share one path in ready and active states
        if (frame_err)
        begin
          rep_req  = 1'b1;
          rep_kind = ctsm_pkg::REPLY_NACK_ONE;
          ret_req  = 1'b1;
        end
        else if (frame_len_i != ctsm_pkg::READ_LEN)
        begin
          ret_req = 1'b1;
        end
        else if (!addr_ok(frame_arg_i) || read_denied)
        begin
          rep_req  = 1'b1;
          rep_kind = ctsm_pkg::REPLY_NACK_ZERO;
          ret_req  = 1'b1;
        end
        else
        begin
          next_state = ctsm_pkg::ST_ACTIVE;
          rd_go      = 1'b1;
          rep_req    = 1'b1;
          rep_kind   = ctsm_pkg::REPLY_READ;
        end
      end
      else
      begin
        unique case (state)
          ctsm_pkg::ST_IDLE,
          ctsm_pkg::ST_HALT:
          begin
            // bad frames and other opcodes leave the state alone
            if (!frame_err && frame_short_i &&
                (frame_op_i == ctsm_pkg::OP_WUPA ||
                 (frame_op_i == ctsm_pkg::OP_REQA && state == ctsm_pkg::ST_IDLE)))
            begin
              next_state = ctsm_pkg::ST_READY1;
              wake       = 1'b1;
              rep_req    = 1'b1;
              rep_kind   = ctsm_pkg::REPLY_ATQA;
            end
          end
          ctsm_pkg::ST_READY1,
          ctsm_pkg::ST_READY2:
          begin
            if (sel_hdr && frame_arg_i == ctsm_pkg::NVB_SELECT &&
                frame_len_i == ctsm_pkg::SEL_LEN)
            begin
              rep_req = 1'b1;
              if (state == ctsm_pkg::ST_READY1)
              begin
                next_state = ctsm_pkg::ST_READY2;
                rep_kind   = ctsm_pkg::REPLY_SAK_PART;
              end
              else
              begin
                next_state = ctsm_pkg::ST_ACTIVE;
                rep_kind   = ctsm_pkg::REPLY_SAK_DONE;
              end
            end
            else if (sel_hdr && frame_arg_i != ctsm_pkg::NVB_SELECT &&
                     frame_len_i >= ctsm_pkg::AC_MIN_LEN &&
                     frame_len_i <= ctsm_pkg::AC_MAX_LEN)
            begin
              // anticollision: answer the remaining uid bits, stay
              rep_req  = 1'b1;
              rep_kind = state == ctsm_pkg::ST_READY1 ?
                         ctsm_pkg::REPLY_UID_CL1 : ctsm_pkg::REPLY_UID_CL2;
            end
            else
            begin
              ret_req = 1'b1;
            end
          end
          ctsm_pkg::ST_ACTIVE:
          begin
            if (frame_short_i)
            begin
              ret_req = 1'b1;
            end
            else if (frame_err && (frame_op_i == ctsm_pkg::OP_HLTA || is_mem_op(frame_op_i)))
            begin
              rep_req  = 1'b1;
              rep_kind = ctsm_pkg::REPLY_NACK_ONE;
              ret_req  = 1'b1;
            end
            else if (frame_op_i == ctsm_pkg::OP_HLTA)
            begin
              if (frame_len_i != ctsm_pkg::HLTA_LEN)
              begin
                ret_req = 1'b1;
              end
              else if (!addr_ok(frame_arg_i))
              begin
                rep_req  = 1'b1;
                rep_kind = ctsm_pkg::REPLY_NACK_ZERO;
                ret_req  = 1'b1;
              end
              else
              begin
                next_state = ctsm_pkg::ST_HALT;
              end
            end
            else if (is_mem_op(frame_op_i))
            begin
              mem_go = 1'b1;
            end
            else
            begin
              ret_req = 1'b1;
            end
          end
        endcase
      end
      if (ret_req)
      begin
        next_state = ret_state;
      end
    end
    else if (mem_err_i && state == ctsm_pkg::ST_ACTIVE)
    begin
      rep_req    = 1'b1;
      rep_kind   = ctsm_pkg::REPLY_NACK_ZERO;
      next_state = ret_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ctsm_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // session origin flag, taken at each wake-up
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      from_halt <= 1'b0;
    end
    else if (wake)
    begin
      from_halt <= state == ctsm_pkg::ST_HALT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration latch: eeprom rewrites mid-session have no effect
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg <= ctsm_pkg::CFG_RESET;
    end
    else if (wake)
    begin
      cfg <= cfg_nv_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // password verification; a pass in the cycle of a clear still counts
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      verified <= 1'b0;
    end
    else if (acs_pass_i && state == ctsm_pkg::ST_ACTIVE)
    begin
      verified <= 1'b1;
    end
    else if (acs_fail_i || state != ctsm_pkg::ST_ACTIVE)
    begin
      verified <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory side strobes and data
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_cmd_o   <= 1'b0;
      rd_start_o  <= 1'b0;
      mem_op_o    <= 8'h00;
      mem_arg_o   <= 8'h00;
      rd_addr_o   <= 8'h00;
      rd_blocks_o <= 3'h0;
    end
    else
    begin
      mem_cmd_o  <= mem_go;
      rd_start_o <= rd_go;
      if (mem_go || rd_go)
      begin
        mem_op_o  <= frame_op_i;
        mem_arg_o <= frame_arg_i;
      end
      if (rd_go)
      begin
        rd_addr_o   <= frame_arg_i;
        rd_blocks_o <= frame_op_i == ctsm_pkg::OP_READ_FOUR ?
                       ctsm_pkg::BLOCKS_FOUR : ctsm_pkg::BLOCKS_TWO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply timing: every answer goes through the frame delay timer
  assign rep.req  = rep_req;
  assign rep.kind = rep_kind;

  ctsm_fdt_timer u_fdt (
    .clk_i  (clk_i),
    .rstn_i (rstn),
    .rep    (rep.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reply_start_o = rep.start;
  assign reply_kind_o  = rep.start_kind;
  assign state_o       = state;
  assign from_halt_o   = from_halt;
  assign cfg_latched_o = cfg;
  assign access_full_o = verified || !cfg[ctsm_pkg::CFG_PWD_EN_BIT];

endmodule : ctsm_tag

`default_nettype wire

// ==== verif/ctsm_tag_checker.sv ====
/*
  Checker of the tag state machine on its top ports.
  Assumes a bind onto ctsm_tag and no frame before start-up.
*/
`timescale 1ns/10ps
`default_nettype none

module ctsm_tag_checker (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // received frame and configuration
  input wire logic       frame_valid_i,
  input wire logic       frame_short_i,
  input wire logic [4:0] frame_len_i,
  input wire logic [7:0] frame_op_i,
  input wire logic [7:0] frame_arg_i,
  input wire logic       err_parity_i,
  input wire logic       err_miller_i,
  input wire logic       err_crc_i,
  input wire logic       uid_match_i,
  input wire logic [7:0] cfg_nv_i,
  // memory unit
  input wire logic       acs_pass_i,
  input wire logic       acs_fail_i,
  input wire logic       mem_err_i,
  input wire logic       mem_cmd_o,
  input wire logic [7:0] mem_op_o,
  input wire logic [7:0] mem_arg_o,
  input wire logic       rd_start_o,
  input wire logic [7:0] rd_addr_o,
  input wire logic [2:0] rd_blocks_o,
  input wire logic       access_full_o,
  input wire logic [7:0] cfg_latched_o,
  // reply and status
  input wire logic       reply_start_o,
  input wire logic [2:0] reply_kind_o,
  input wire logic [2:0] state_o,
  input wire logic       from_halt_o
);
  logic ok;
  logic lf;

  // clean frames, and clean four-byte frames
  assign ok = !err_parity_i && !err_miller_i && !err_crc_i;
  assign lf = frame_valid_i && !frame_short_i && frame_len_i == 5'h04 && ok;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////////
  // reply timing: anticollision needs every tag to answer in step
  a_reply_pulse: assert property (reply_start_o |=> !reply_start_o)
    else $error("reply strobe longer than a cycle");
  a_atqa_delay: assert property (
    reply_start_o && reply_kind_o == 3'h0 |-> $past(frame_valid_i, 865))
    else $error("wake answer off the frame delay");

  ////////////////////////////////////////////////////////////////////////////
  // wake-up, halt and configuration latch
  a_idle_wake: assert property (
    state_o == 3'h0 && frame_valid_i && frame_short_i && ok
    && (frame_op_i == ctsm_pkg::OP_REQA || frame_op_i == ctsm_pkg::OP_WUPA)
    |=> state_o == 3'h1 && cfg_latched_o == $past(cfg_nv_i))
    else $error("wake from idle missed");
  a_halt_stay: assert property (
    state_o == 3'h4 && frame_valid_i
    && !(frame_short_i && frame_op_i == ctsm_pkg::OP_WUPA) |=> state_o == 3'h4)
    else $error("halt left without wake");
  a_halt_wake: assert property (
    state_o == 3'h4 && frame_valid_i && frame_short_i && ok
    && frame_op_i == ctsm_pkg::OP_WUPA |=> state_o == 3'h1 && from_halt_o)
    else $error("wake from halt missed");
  a_halt_entry: assert property (
    state_o == 3'h3 && lf && frame_op_i == ctsm_pkg::OP_HLTA
    && frame_arg_i <= ctsm_pkg::ADDR_LAST |=> state_o == 3'h4)
    else $error("halt command not taken");
  a_cfg_hold: assert property (
    state_o != 3'h0 && state_o != 3'h4 |=> $stable(cfg_latched_o))
    else $error("latched config changed mid-session");

  ////////////////////////////////////////////////////////////////////////////
  // read shortcut and active-state checksum error
  a_read_short: assert property (
    (state_o == 3'h1 || state_o == 3'h2) && lf && !cfg_latched_o[1]
    && frame_op_i == ctsm_pkg::OP_READ_FOUR && frame_arg_i <= ctsm_pkg::ADDR_LAST
    |=> state_o == 3'h3 && rd_start_o && rd_blocks_o == 3'h4
    && rd_addr_o == $past(frame_arg_i))
    else $error("read shortcut not taken");
  a_crc_return: assert property (
    state_o == 3'h3 && frame_valid_i && !frame_short_i && err_crc_i
    && (frame_op_i == ctsm_pkg::OP_READ_FOUR || frame_op_i == ctsm_pkg::OP_READ_TWO)
    |=> state_o == ($past(from_halt_o) ? 3'h4 : 3'h0))
    else $error("checksum error kept the tag active");
endmodule : ctsm_tag_checker

bind ctsm_tag ctsm_tag_checker u_chk (.*);

`default_nettype wire

// ==== verif/ctsm_reader_model.sv ====
/*
  Reader model: one decoded frame per call of send.
  Assumes the caller keeps start-up wait and reply spacing.
*/
`timescale 1ns/10ps
`default_nettype none

module ctsm_reader_model (
  // clock
  input  wire logic       clk_i,
  // decoded frame towards the tag
  output logic            fv_o,
  output logic            short_o,
  output logic [4:0]      len_o,
  output logic [7:0]      op_o,
  output logic [7:0]      arg_o,
  output logic            par_o,
  output logic            mil_o,
  output logic            crc_o,
  output logic            uid_o
);
  // quiet lines at time zero; only checksum errors are ever injected
  initial
  begin
    {fv_o, short_o, len_o, op_o, arg_o, par_o, mil_o, crc_o, uid_o} = 27'h0000001;
  end

  // one-cycle frame; fields invert after it so stale values never match
  task automatic send(input logic s, input logic [4:0] l, input logic [7:0] o,
                      input logic [7:0] a, input logic c);
    @(posedge clk_i);
    fv_o <= 1'b1;
    short_o <= s;
    len_o <= l;
    op_o <= o;
    arg_o <= a;
    crc_o <= c;
    @(posedge clk_i);
    fv_o <= 1'b0;
    len_o <= ~l;
    op_o <= ~o;
    arg_o <= ~a;
  endtask : send
endmodule : ctsm_reader_model

`default_nettype wire

// ==== verif/ctsm_tag_tb.sv ====
/*
  Self-checking bench of the tag state machine.
  Assumes an 864-cycle frame delay and 1200-cycle start-up.
*/
`timescale 1ns/10ps
`default_nettype none

module ctsm_tag_tb;
  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic [7:0] cfg_nv_i = 8'h00;
  logic       acs_pass_i = 1'b0;
  logic       acs_fail_i = 1'b0;
  logic       mem_err_i = 1'b0;
  logic       frame_valid_i, frame_short_i, err_parity_i, err_miller_i, err_crc_i;
  logic       uid_match_i, reply_start_o, from_halt_o;
  logic [4:0] frame_len_i;
  logic [7:0] frame_op_i, frame_arg_i, rd_addr_o, cfg_latched_o;
  logic [2:0] rd_blocks_o, reply_kind_o, state_o;
  int         err_count = 0;
  int         check_count = 0;

  ctsm_tag uut (
    .clk_i, .rstn_i, .frame_valid_i, .frame_short_i, .frame_len_i, .frame_op_i,
    .frame_arg_i, .err_parity_i, .err_miller_i, .err_crc_i, .uid_match_i, .cfg_nv_i,
    .acs_pass_i, .acs_fail_i, .mem_err_i, .mem_cmd_o(), .mem_op_o(), .mem_arg_o(),
    .rd_start_o(), .rd_addr_o, .rd_blocks_o, .access_full_o(), .cfg_latched_o,
    .reply_start_o, .reply_kind_o, .state_o, .from_halt_o
  );
  ctsm_reader_model rdr (
    .clk_i, .fv_o(frame_valid_i), .short_o(frame_short_i), .len_o(frame_len_i),
    .op_o(frame_op_i), .arg_o(frame_arg_i), .par_o(err_parity_i),
    .mil_o(err_miller_i), .crc_o(err_crc_i), .uid_o(uid_match_i)
  );

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // comparisons and the verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t value %0h not %0h", $time, g, e);
    end
  endtask : chk

  task automatic chkt(input int g, input int e);
    check_count++;
    if (g != e)
    begin
      err_count++;
      $display("BAD %0t reply at cycle %0d not %0d", $time, g, e);
    end
  endtask : chkt

  task automatic tally_and_finish;
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // one frame: next state, then reply cycle (0 for none) and kind
  task automatic xfer(input logic s, input logic [4:0] l, input logic [7:0] o,
                      input logic [7:0] a, input logic c, input logic [2:0] st,
                      input int n, input logic [2:0] k);
    int t;
    t = 0;
    rdr.send(s, l, o, a, c);
    #1 chk(8'(state_o), 8'(st));
    for (int i = 1; i <= 900; i++)
    begin
      @(posedge clk_i);
      #1;
      if (reply_start_o === 1'b1)
      begin
        t = i;
        chk(8'(reply_kind_o), 8'(k));
      end
    end
    chkt(t, n);
  endtask : xfer

  // short wake frame answered by the request answer in ready1
  task automatic wk(input logic [7:0] o);
    xfer(1'b1, 5'h01, o, 8'h00, 1'b0, 3'h1, 864, 3'h0);
  endtask : wk

  // reset, then wait out the tag's start-up before any frame
  task automatic do_reset;
    rstn_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (1210) @(posedge clk_i);
    #1 chk(8'(state_o), 8'h00);
    chk(8'(from_halt_o), 8'h00);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // stray frame in idle, wake with read protect, protected read denied
  task automatic t_wake;
    xfer(1'b0, 5'h04, 8'h30, 8'h00, 1'b0, 3'h0, 0, 3'h0);
    @(posedge clk_i) cfg_nv_i <= 8'h03;
    wk(8'h26);
    @(posedge clk_i) cfg_nv_i <= 8'h00;
    xfer(1'b0, 5'h09, 8'h93, 8'h70, 1'b0, 3'h2, 864, 3'h3);
    chk(cfg_latched_o, 8'h03);
    xfer(1'b0, 5'h04, 8'h30, 8'h25, 1'b0, 3'h0, 864, 3'h6);
  endtask : t_wake

  // full cascade, halt, ignored request, wake from halt
  task automatic t_select;
    wk(8'h26);
    xfer(1'b0, 5'h09, 8'h93, 8'h70, 1'b0, 3'h2, 864, 3'h3);
    xfer(1'b0, 5'h09, 8'h95, 8'h70, 1'b0, 3'h3, 864, 3'h4);
    xfer(1'b0, 5'h04, 8'h50, 8'h00, 1'b0, 3'h4, 0, 3'h0);
    xfer(1'b1, 5'h01, 8'h26, 8'h00, 1'b0, 3'h4, 0, 3'h0);
    wk(8'h52);
    chk(8'(from_halt_o), 8'h01);
  endtask : t_select

  // two-block shortcut at the top address, then checksum error back to halt
  task automatic t_shortcut;
    xfer(1'b0, 5'h04, 8'h31, 8'h25, 1'b0, 3'h3, 864, 3'h5);
    chk(8'(rd_blocks_o), 8'h02);
    chk(rd_addr_o, 8'h25);
    xfer(1'b0, 5'h04, 8'h30, 8'h01, 1'b1, 3'h4, 864, 3'h7);
  endtask : t_shortcut

  // error returns to idle: bad address, bad opcode, halt in a ready state
  task automatic t_errors;
    wk(8'h26);
    xfer(1'b0, 5'h04, 8'h31, 8'h26, 1'b0, 3'h0, 864, 3'h6);
    wk(8'h52);
    xfer(1'b0, 5'h04, 8'h30, 8'h0E, 1'b0, 3'h3, 864, 3'h5);
    chk(8'(rd_blocks_o), 8'h04);
    xfer(1'b0, 5'h04, 8'h30, 8'h26, 1'b0, 3'h0, 864, 3'h6);
    wk(8'h26);
    xfer(1'b0, 5'h09, 8'h93, 8'h70, 1'b0, 3'h2, 864, 3'h3);
    xfer(1'b0, 5'h09, 8'h95, 8'h70, 1'b0, 3'h3, 864, 3'h4);
    xfer(1'b0, 5'h04, 8'h77, 8'h00, 1'b0, 3'h0, 0, 3'h0);
    wk(8'h26);
    xfer(1'b0, 5'h04, 8'h50, 8'h00, 1'b0, 3'h0, 0, 3'h0);
  endtask : t_errors

  ////////////////////////////////////////////////////////////////////////////
  // main sequence, with a second reset in mid-run
  initial
  begin
    do_reset();
    t_wake();
    t_select();
    t_shortcut();
    do_reset();
    t_errors();
    tally_and_finish();
  end

  // watchdog well beyond the 23 frames and two resets
  initial
  begin
    #4000000;
    err_count++;
    tally_and_finish();
  end
endmodule : ctsm_tag_tb

`default_nettype wire
